/* File: rtl/cfh_map.svh */
`ifndef CFH_MAP_SVH
`define CFH_MAP_SVH

// **********************************************************************
// Clock and strobe timing
// **********************************************************************
`define CFH_CLK_PERIOD_NS 5
`define CFH_T_SETUP_NS 30
`define CFH_T_STROBE_NS 80
`define CFH_T_RECOV_NS 50
// Least times, rounded up to whole cycles
`define CFH_SETUP_CYC ((`CFH_T_SETUP_NS + `CFH_CLK_PERIOD_NS - 1) / `CFH_CLK_PERIOD_NS)
`define CFH_STROBE_CYC ((`CFH_T_STROBE_NS + `CFH_CLK_PERIOD_NS - 1) / `CFH_CLK_PERIOD_NS)
`define CFH_RECOV_CYC ((`CFH_T_RECOV_NS + `CFH_CLK_PERIOD_NS - 1) / `CFH_CLK_PERIOD_NS)

// **********************************************************************
// Bus widths and buffer depth
// **********************************************************************
`define CFH_ADDR_W 11
`define CFH_DATA_W 16
`define CFH_BUF_DEPTH 16
`define CFH_BUF_AW 4

`endif

/* File: rtl/cfh_pkg.sv */
package cfh_pkg;

   // **********************************************************************
   // Types
   // **********************************************************************
   typedef enum logic [1:0] {
      CFH_MODE_MEM = 2'h0,
      CFH_MODE_IO = 2'h1,
      CFH_MODE_IDE = 2'h2
   } cfh_mode_type;

   typedef enum logic [3:0] {
      CFH_ST_IDLE = 4'h1,
      CFH_ST_SETUP = 4'h2,
      CFH_ST_STROBE = 4'h4,
      CFH_ST_RECOV = 4'h8
   } cfh_state_type;

endpackage : cfh_pkg

/* File: rtl/cfh_word_mem.sv */
`timescale 1ns/10ps
module cfh_word_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);

   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   // Registered read: data for an address appear one cycle later
   always_ff @(posedge clk_i) begin
      rdata_o <= mem_r[raddr_i];
   end

endmodule : cfh_word_mem

/* File: rtl/cfh_host.sv */
`timescale 1ns/10ps
`include "cfh_map.svh"
// Function
// - Host enables its input data buffer from input acknowledge during I/O reads.
// - Host sets each DMA word's direction by pulsing the read or write strobe.
// - Request held until grant, then dropped; raised again while data remain.
// - Host makes the read strobe in I/O and IDE modes; card drives data meanwhile.
// - During grant both register selects stay deasserted; transfers are 16 bits.
// - Host drives disk mode select low to enter True IDE mode.
module cfh_host
   import cfh_pkg::*;
#(
   parameter int AW = `CFH_ADDR_W,
   parameter int DW = `CFH_DATA_W,
   parameter int DEPTH = `CFH_BUF_DEPTH,
   parameter int BAW = `CFH_BUF_AW
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire cfh_mode_type mode_i,
   input wire logic dma_enable_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic cmd_control_i,
   input wire logic [AW-1:0] cmd_addr_i,
   input wire logic [DW-1:0] cmd_wdata_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [DW-1:0] rsp_data_o,
   output logic rsp_acked_o,
   input wire logic dma_start_i,
   input wire logic dma_write_i,
   input wire logic [BAW:0] dma_len_i,
   output logic dma_busy_o,
   output logic dma_done_o,
   input wire logic buf_wr_en_i,
   input wire logic [BAW-1:0] buf_addr_i,
   input wire logic [DW-1:0] buf_wdata_i,
   input wire logic [BAW-1:0] buf_rd_addr_i,
   output logic [DW-1:0] buf_rdata_o,
   output logic [AW-1:0] addr_o,
   input wire logic [DW-1:0] data_i,
   output logic [DW-1:0] data_o,
   output logic data_oe_n_o,
   output logic io_read_strobe_n_o,
   output logic io_write_strobe_n_o,
   output logic taskfile_select_n_o,
   output logic control_block_select_n_o,
   output logic transfer_grant_n_o,
   output logic disk_mode_select_n_o,
   output logic read_buffer_en_o,
   input wire logic input_acknowledge_n_i,
   input wire logic transfer_request_i
);

   // **********************************************************************
   // Helpers
   // **********************************************************************
   function automatic logic [7:0] last_cnt(input int cycles);
      last_cnt = (cycles > 1) ? 8'(cycles - 1) : 8'h00;
   endfunction : last_cnt

   cfh_state_type state_r;
   cfh_mode_type mode_r;
   logic [7:0] cnt_r;
   logic write_r;
   logic in_dma_r;
   logic dma_active_r;
   logic dma_dir_write_r;
   logic [BAW:0] rem_r;
   logic [BAW-1:0] idx_r;
   logic ack_seen_r;
   logic dma_go;
   logic pio_go;
   logic more_words;
   logic dma_capture;
   logic mem_we;
   logic [BAW-1:0] mem_waddr;
   logic [DW-1:0] mem_wdata;
   logic [BAW-1:0] mem_raddr;
   logic [DW-1:0] mem_rdata;

   // **********************************************************************
   // Start conditions
   // **********************************************************************
   // DMA only in IDE mode with DMA enabled, so older cards never see a grant
   assign dma_go = dma_active_r && dma_enable_i && (mode_r == CFH_MODE_IDE)
                   && transfer_request_i;
   assign pio_go = cmd_valid_i && !dma_go;
   assign more_words = (rem_r > {{BAW{1'b0}}, 1'b1}) && transfer_request_i;
   assign dma_capture = (state_r == CFH_ST_STROBE) && in_dma_r && !write_r
                        && (cnt_r == last_cnt(`CFH_STROBE_CYC));

   // **********************************************************************
   // Mode pin
   // **********************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_r <= CFH_MODE_MEM;
         disk_mode_select_n_o <= 1'b1;
      end else if (state_r == CFH_ST_IDLE && !dma_active_r) begin
         // Mode changes only between cycles so no strobe straddles it
         mode_r <= mode_i;
         disk_mode_select_n_o <= (mode_i != CFH_MODE_IDE);
      end
   end

   // **********************************************************************
   // Cycle sequencer
   // **********************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= CFH_ST_IDLE;
         cnt_r <= 8'h00;
         write_r <= 1'b0;
         in_dma_r <= 1'b0;
      end else begin
         unique case (state_r)
            CFH_ST_IDLE: begin
               cnt_r <= 8'h00;
               if (dma_go) begin
                  state_r <= CFH_ST_SETUP;
                  write_r <= dma_dir_write_r;
                  in_dma_r <= 1'b1;
               end else if (pio_go) begin
                  state_r <= CFH_ST_SETUP;
                  write_r <= cmd_write_i;
                  in_dma_r <= 1'b0;
               end
            end
            CFH_ST_SETUP: begin
               if (cnt_r == last_cnt(`CFH_SETUP_CYC)) begin
                  state_r <= CFH_ST_STROBE;
                  cnt_r <= 8'h00;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            CFH_ST_STROBE: begin
               if (cnt_r == last_cnt(`CFH_STROBE_CYC)) begin
                  state_r <= CFH_ST_RECOV;
                  cnt_r <= 8'h00;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            CFH_ST_RECOV: begin
               if (cnt_r == last_cnt(`CFH_RECOV_CYC)) begin
                  cnt_r <= 8'h00;
                  // Burst continues only while the card still requests
                  state_r <= (in_dma_r && more_words) ? CFH_ST_SETUP : CFH_ST_IDLE;
                  in_dma_r <= in_dma_r && more_words;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
         endcase
      end
   end

   // **********************************************************************
   // Pin drivers
   // **********************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         io_read_strobe_n_o <= 1'b1;
         io_write_strobe_n_o <= 1'b1;
      end else begin
         // Strobe only in I/O and IDE modes; write_r, from the command or the DMA direction, picks which one
         io_read_strobe_n_o <= !((state_r == CFH_ST_SETUP)
                               && (cnt_r == last_cnt(`CFH_SETUP_CYC))
                               && !write_r && (mode_r != CFH_MODE_MEM)
                               || (state_r == CFH_ST_STROBE) && !io_read_strobe_n_o
                               && (cnt_r != last_cnt(`CFH_STROBE_CYC)));
         // Rising edge at the end of the pulse is where the card takes the data
         io_write_strobe_n_o <= !((state_r == CFH_ST_SETUP)
                                && (cnt_r == last_cnt(`CFH_SETUP_CYC))
                                && write_r && (mode_r != CFH_MODE_MEM)
                                || (state_r == CFH_ST_STROBE) && !io_write_strobe_n_o
                                && (cnt_r != last_cnt(`CFH_STROBE_CYC)));
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         transfer_grant_n_o <= 1'b1;
         taskfile_select_n_o <= 1'b1;
         control_block_select_n_o <= 1'b1;
         addr_o <= '0;
      end else if (state_r == CFH_ST_IDLE && dma_go) begin
         transfer_grant_n_o <= 1'b0;
         taskfile_select_n_o <= 1'b1;
         control_block_select_n_o <= 1'b1;
      end else if (state_r == CFH_ST_IDLE && pio_go) begin
         addr_o <= cmd_addr_i;
         taskfile_select_n_o <= cmd_control_i && (mode_r == CFH_MODE_IDE);
         control_block_select_n_o <= !(cmd_control_i && (mode_r == CFH_MODE_IDE));
      end else if (state_r == CFH_ST_RECOV && cnt_r == last_cnt(`CFH_RECOV_CYC)
                   && !(in_dma_r && more_words)) begin
         transfer_grant_n_o <= 1'b1;
         taskfile_select_n_o <= 1'b1;
         control_block_select_n_o <= 1'b1;
      end
   end

   // Data drive: whole 16-bit words in DMA, held through recovery for hold time
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_o <= '0;
         data_oe_n_o <= 1'b1;
      end else if (state_r == CFH_ST_IDLE && pio_go && !dma_go) begin
         data_o <= cmd_wdata_i;
         data_oe_n_o <= !cmd_write_i;
      end else if (state_r == CFH_ST_SETUP && in_dma_r) begin
         data_o <= mem_rdata;
         data_oe_n_o <= !write_r;
      end else if (state_r == CFH_ST_IDLE) begin
         data_oe_n_o <= 1'b1;
      end
   end

   // **********************************************************************
   // Read path and input buffer enable
   // **********************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         read_buffer_en_o <= 1'b0;
         ack_seen_r <= 1'b0;
      end else begin
         // Acknowledge counts only in I/O mode and only under our own read strobe
         read_buffer_en_o <= (mode_r == CFH_MODE_IO) && !io_read_strobe_n_o
                             && !input_acknowledge_n_i;
         if (state_r == CFH_ST_SETUP) begin
            ack_seen_r <= 1'b0;
         end else if ((mode_r == CFH_MODE_IO) && !io_read_strobe_n_o
                      && !input_acknowledge_n_i) begin
            ack_seen_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o <= '0;
         rsp_acked_o <= 1'b0;
      end else begin
         rsp_valid_o <= 1'b0;
         if (state_r == CFH_ST_STROBE && !in_dma_r && !write_r
             && cnt_r == last_cnt(`CFH_STROBE_CYC)) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= data_i;
            rsp_acked_o <= ack_seen_r || !input_acknowledge_n_i && (mode_r == CFH_MODE_IO);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_ready_o <= 1'b0;
      end else begin
         cmd_ready_o <= (state_r == CFH_ST_IDLE) && !cmd_valid_i && !dma_go;
      end
   end

   // **********************************************************************
   // DMA burst bookkeeping
   // **********************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dma_active_r <= 1'b0;
         dma_dir_write_r <= 1'b0;
         rem_r <= '0;
         idx_r <= '0;
         dma_busy_o <= 1'b0;
         dma_done_o <= 1'b0;
      end else begin
         dma_done_o <= 1'b0;
         if (!dma_active_r && dma_start_i && dma_len_i != '0 && state_r == CFH_ST_IDLE) begin
            dma_active_r <= 1'b1;
            dma_busy_o <= 1'b1;
            dma_dir_write_r <= dma_write_i;
            rem_r <= dma_len_i;
            idx_r <= '0;
         end else if (in_dma_r && state_r == CFH_ST_RECOV
                      && cnt_r == last_cnt(`CFH_RECOV_CYC)) begin
            rem_r <= rem_r - {{BAW{1'b0}}, 1'b1};
            idx_r <= idx_r + {{(BAW-1){1'b0}}, 1'b1};
            if (rem_r == {{BAW{1'b0}}, 1'b1}) begin
               dma_active_r <= 1'b0;
               dma_busy_o <= 1'b0;
               dma_done_o <= 1'b1;
            end
         end
      end
   end

   // **********************************************************************
   // Word buffer
   // **********************************************************************
   assign mem_we = dma_capture || buf_wr_en_i;
   assign mem_waddr = dma_capture ? idx_r : buf_addr_i;
   assign mem_wdata = dma_capture ? data_i : buf_wdata_i;
   // Limitation: the user read port returns burst data while a burst runs
   assign mem_raddr = dma_active_r ? idx_r : buf_rd_addr_i;

   cfh_word_mem #(
      .WIDTH(DW),
      .DEPTH(DEPTH),
      .AW(BAW)
   ) u_buf (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(mem_wdata),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   assign buf_rdata_o = mem_rdata;

   // **********************************************************************
   // Checks
   // **********************************************************************
   property p_grant_no_select;
      @(posedge clk_i) disable iff (reset_i)
      !transfer_grant_n_o |-> taskfile_select_n_o && control_block_select_n_o;
   endproperty
   a_grant_no_select: assert property (p_grant_no_select)
      else $error("register select active during grant");

   property p_grant_after_request;
      @(posedge clk_i) disable iff (reset_i)
      $fell(transfer_grant_n_o) |-> $past(transfer_request_i) && $past(dma_enable_i);
   endproperty
   a_grant_after_request: assert property (p_grant_after_request)
      else $error("grant raised without request");

   property p_one_strobe;
      @(posedge clk_i) disable iff (reset_i)
      io_read_strobe_n_o || io_write_strobe_n_o;
   endproperty
   a_one_strobe: assert property (p_one_strobe)
      else $error("both strobes active");

   property p_dma_dir;
      @(posedge clk_i) disable iff (reset_i)
      !transfer_grant_n_o && $fell(io_write_strobe_n_o) |-> dma_dir_write_r;
   endproperty
   a_dma_dir: assert property (p_dma_dir)
      else $error("write strobe against DMA direction");

   property p_strobe_mode;
      @(posedge clk_i) disable iff (reset_i)
      $fell(io_read_strobe_n_o) |-> mode_r != CFH_MODE_MEM;
   endproperty
   a_strobe_mode: assert property (p_strobe_mode)
      else $error("read strobe in memory mode");

   property p_strobe_width;
      @(posedge clk_i) disable iff (reset_i)
      $fell(io_read_strobe_n_o) |-> !io_read_strobe_n_o [*8];
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("read strobe too short");

   property p_buffer_en;
      @(posedge clk_i) disable iff (reset_i)
      read_buffer_en_o |-> $past(mode_r == CFH_MODE_IO) && $past(!input_acknowledge_n_i);
   endproperty
   a_buffer_en: assert property (p_buffer_en)
      else $error("buffer enabled without acknowledge");

   property p_ide_pin;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == CFH_ST_SETUP) |-> disk_mode_select_n_o == (mode_r != CFH_MODE_IDE);
   endproperty
   a_ide_pin: assert property (p_ide_pin)
      else $error("disk mode pin disagrees with mode");

endmodule : cfh_host

/* File: verif/cfh_card_model.sv */
`timescale 1ns/10ps
// **********************************************************************
// Card side of the port: acknowledge, request and data answers
// **********************************************************************
module cfh_card_model
   import cfh_pkg::*;
#(
   parameter int AW = 11,
   parameter int DW = 16,
   parameter int OWN_LIMIT = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic io_mode_i,
   input wire logic dma_on_i,
   input wire logic ready_i,
   input wire logic load_i,
   input wire logic [4:0] words_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] host_data_i,
   input wire logic io_read_strobe_n_i,
   input wire logic io_write_strobe_n_i,
   input wire logic taskfile_select_n_i,
   input wire logic control_block_select_n_i,
   input wire logic transfer_grant_n_i,
   input wire logic disk_mode_select_n_i,
   output logic [DW-1:0] card_data_o,
   output logic card_oe_o,
   output logic input_acknowledge_n_o,
   output logic transfer_request_o,
   output logic transfer_request_oe_o,
   output logic [DW-1:0] wr_data_o
);
   logic ide, own, reg_sel, granted, rd_prev_n_r, wr_prev_n_r, req_r, rise;
   logic [4:0] rem_r, idx_r;
   assign ide = !disk_mode_select_n_i;
   assign own = (32'(addr_i) < OWN_LIMIT);
   assign reg_sel = !taskfile_select_n_i || (ide && !control_block_select_n_i);
   assign granted = ide && dma_on_i && !transfer_grant_n_i;
   // Combinational, so the acknowledge can never outlast the read strobe
   assign input_acknowledge_n_o = !(io_mode_i && !ide && reg_sel && own
                                    && !io_read_strobe_n_i);
   assign card_oe_o = !io_read_strobe_n_i
                      && (granted || (reg_sel && (ide || (io_mode_i && own))));
   assign card_data_o = granted ? (16'hD000 + 16'(idx_r)) : (16'hC000 | 16'(addr_i));
   assign transfer_request_o = req_r;
   assign transfer_request_oe_o = ide;
   assign rise = (io_read_strobe_n_i && !rd_prev_n_r) || (io_write_strobe_n_i && !wr_prev_n_r);
   always_ff @(posedge clk_i) begin
      rd_prev_n_r <= io_read_strobe_n_i;
      wr_prev_n_r <= io_write_strobe_n_i;
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_data_o <= '0;
      end else if (io_write_strobe_n_i && !wr_prev_n_r && (granted || reg_sel)) begin
         wr_data_o <= host_data_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i || load_i) begin
         rem_r <= reset_i ? 5'h0 : words_i;
         idx_r <= 5'h0;
         req_r <= 1'b0;
      end else begin
         if (granted && rise) begin
            rem_r <= rem_r - 5'h1;
            idx_r <= idx_r + 5'h1;
         end
         if (granted) begin
            req_r <= 1'b0;
         end else if (transfer_grant_n_i && ready_i && rem_r != 5'h0) begin
            req_r <= 1'b1;
         end
      end
   end
endmodule : cfh_card_model

/* File: verif/cfh_host_tb.sv */
`timescale 1ns/10ps
module cfh_host_tb;
   import cfh_pkg::*;
   logic clk = 0, reset = 1, dma_enable = 0, cmd_valid = 0, cmd_write = 0, cmd_control = 0;
   cfh_mode_type mode = CFH_MODE_MEM;
   logic [10:0] cmd_addr = '0, addr;
   logic [15:0] cmd_wdata = '0, buf_wdata = '0, rsp_data, buf_rdata, data_in, data_out;
   logic [15:0] last_data_r = '0, card_data, card_wr_data, rsp_q;
   logic dma_start = 0, dma_write = 0, buf_wr_en = 0, card_on = 1, card_ready = 1, card_load = 0;
   logic [4:0] dma_len = '0, card_words = '0;
   logic [3:0] buf_addr = '0, buf_rd_addr = '0;
   logic cmd_ready, rsp_valid, rsp_acked, dma_busy, dma_done, data_oe_n, rd_n, wr_n, tf_n, cb_n;
   logic grant_n, disk_n, rbe, ack_n, card_oe, card_req, req_oe, float_r = 0, rd_prev, wr_prev;
   logic grant_prev, got_rsp, ack_q, rbe_seen, done;
   logic [15:0] rd_falls, wr_falls, grant_falls, grant_cyc, cs_bad, rd_cyc;
   int mismatches = 0, check_count = 0;
   // Released lines show a changing value so a stale level cannot pass
   assign data_in = card_oe ? card_data : (!data_oe_n ? data_out : ~last_data_r);
   cfh_host dut_u (.clk_i(clk), .reset_i(reset), .mode_i(mode), .dma_enable_i(dma_enable),
      .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_control_i(cmd_control),
      .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_acked_o(rsp_acked),
      .dma_start_i(dma_start), .dma_write_i(dma_write), .dma_len_i(dma_len),
      .dma_busy_o(dma_busy), .dma_done_o(dma_done), .buf_wr_en_i(buf_wr_en),
      .buf_addr_i(buf_addr), .buf_wdata_i(buf_wdata), .buf_rd_addr_i(buf_rd_addr),
      .buf_rdata_o(buf_rdata), .addr_o(addr), .data_i(data_in), .data_o(data_out),
      .data_oe_n_o(data_oe_n), .io_read_strobe_n_o(rd_n), .io_write_strobe_n_o(wr_n),
      .taskfile_select_n_o(tf_n), .control_block_select_n_o(cb_n),
      .transfer_grant_n_o(grant_n), .disk_mode_select_n_o(disk_n), .read_buffer_en_o(rbe),
      .input_acknowledge_n_i(ack_n), .transfer_request_i(req_oe ? card_req : float_r));
   cfh_card_model card_u (.clk_i(clk), .reset_i(reset), .io_mode_i(mode == CFH_MODE_IO),
      .dma_on_i(card_on), .ready_i(card_ready), .load_i(card_load), .words_i(card_words),
      .addr_i(addr), .host_data_i(data_out), .io_read_strobe_n_i(rd_n),
      .io_write_strobe_n_i(wr_n), .taskfile_select_n_i(tf_n), .control_block_select_n_i(cb_n),
      .transfer_grant_n_i(grant_n), .disk_mode_select_n_i(disk_n), .card_data_o(card_data),
      .card_oe_o(card_oe), .input_acknowledge_n_o(ack_n), .transfer_request_o(card_req),
      .transfer_request_oe_o(req_oe), .wr_data_o(card_wr_data));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // **********************************************************************
   // Wire monitor
   // **********************************************************************
   always @(posedge clk) begin
      float_r <= ~float_r;
      last_data_r <= data_in;
      rd_prev <= rd_n;
      wr_prev <= wr_n;
      grant_prev <= grant_n;
      if (!rd_n && rd_prev) rd_falls <= rd_falls + 16'h1;
      if (!wr_n && wr_prev) wr_falls <= wr_falls + 16'h1;
      if (!grant_n && grant_prev) grant_falls <= grant_falls + 16'h1;
      if (!grant_n) grant_cyc <= grant_cyc + 16'h1;
      if (!grant_n && (!tf_n || !cb_n)) cs_bad <= cs_bad + 16'h1;
      if (!rd_n) rd_cyc <= rd_cyc + 16'h1;
      if (rbe) rbe_seen <= 1'b1;
   end
   // **********************************************************************
   // Shared tasks
   // **********************************************************************
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0, got}, {15'h0, exp});
   endtask : chk_bit
   task automatic clr_counts();
      {rd_falls, wr_falls, grant_falls, grant_cyc, cs_bad, rd_cyc} = '0;
      rbe_seen = 0;
   endtask : clr_counts
   task automatic set_mode(input cfh_mode_type m);
      tick();
      mode = m;
      repeat (4) tick();
   endtask : set_mode
   task automatic pio(input logic w, input logic ctl, input logic [10:0] a, input logic [15:0] wd);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      if (n >= 100) mismatches++;
      clr_counts();
      got_rsp = 0;
      {cmd_write, cmd_control, cmd_addr, cmd_wdata, cmd_valid} = {w, ctl, a, wd, 1'b1};
      n = 0;
      do begin
         tick();
         n++;
      end while (cmd_ready === 1'b1 && n < 50);
      cmd_valid = 0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         if (rsp_valid === 1'b1) {got_rsp, rsp_q, ack_q} = {1'b1, rsp_data, rsp_acked};
         tick();
         n++;
      end
      if (n >= 100) mismatches++;
   endtask : pio
   task automatic load_card(input logic [4:0] w);
      card_words = w;
      card_load = 1;
      tick();
      card_load = 0;
   endtask : load_card
   task automatic start_dma(input logic w, input logic [4:0] len);
      tick();
      clr_counts();
      {dma_write, dma_len, dma_start} = {w, len, 1'b1};
      tick();
      dma_start = 0;
   endtask : start_dma
   task automatic wait_dma();
      int n;
      n = 0;
      done = 0;
      while (!done && n < 1000) begin
         tick();
         n++;
         if (dma_done === 1'b1) done = 1;
      end
      if (!done) mismatches++;
   endtask : wait_dma
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // **********************************************************************
   // Scenarios
   // **********************************************************************
   task automatic t_io_mode();
      set_mode(CFH_MODE_IO);
      chk_bit(disk_n, 1'b1);
      pio(1'b0, 1'b0, 11'h005, 16'h0);
      chk_bit(got_rsp, 1'b1);
      chk_word(rsp_q, 16'hC005);
      chk_word(rd_cyc, 16'h10);
      chk_bit(ack_q, 1'b1);
      chk_bit(rbe_seen, 1'b1);
      chk_bit(rbe, 1'b0);
      pio(1'b0, 1'b0, 11'h234, 16'h0);
      chk_bit(ack_q, 1'b0);
      chk_bit(rbe_seen, 1'b0);
      pio(1'b1, 1'b0, 11'h003, 16'h5A3C);
      chk_word(card_wr_data, 16'h5A3C);
      chk_word(wr_falls, 16'h1);
      $display("test io_mode done");
   endtask : t_io_mode
   task automatic t_mem_mode();
      set_mode(CFH_MODE_MEM);
      pio(1'b0, 1'b0, 11'h005, 16'h0);
      chk_word(rd_falls, 16'h0);
      chk_bit(rbe_seen, 1'b0);
      chk_bit(got_rsp, 1'b1);
      $display("test mem_mode done");
   endtask : t_mem_mode
   task automatic t_ide_dma();
      set_mode(CFH_MODE_IDE);
      chk_bit(disk_n, 1'b0);
      pio(1'b0, 1'b1, 11'h006, 16'h0);
      chk_word(rsp_q, 16'hC006);
      card_ready = 0;
      load_card(5'h3);
      dma_enable = 1;
      start_dma(1'b0, 5'h3);
      repeat (20) tick();
      chk_word(grant_cyc, 16'h0);
      card_ready = 1;
      wait_dma();
      chk_bit(done, 1'b1);
      chk_word(rd_falls, 16'h3);
      chk_word(wr_falls, 16'h0);
      chk_word(grant_falls, 16'h3);
      chk_word(cs_bad, 16'h0);
      chk_bit(grant_n, 1'b1);
      for (int i = 0; i < 3; i++) begin
         buf_rd_addr = 4'(i);
         repeat (2) tick();
         chk_word(buf_rdata, 16'hD000 + 16'(i));
      end
      {buf_wr_en, buf_addr, buf_wdata} = {1'b1, 4'h0, 16'h1234};
      tick();
      {buf_addr, buf_wdata} = {4'h1, 16'hABCD};
      tick();
      buf_wr_en = 0;
      load_card(5'h2);
      start_dma(1'b1, 5'h2);
      wait_dma();
      chk_word(wr_falls, 16'h2);
      chk_word(rd_falls, 16'h0);
      chk_word(card_wr_data, 16'hABCD);
      chk_word(cs_bad, 16'h0);
      $display("test ide_dma done");
   endtask : t_ide_dma
   task automatic t_dma_off();
      {dma_enable, card_on} = 2'b00;
      load_card(5'h1);
      start_dma(1'b0, 5'h1);
      repeat (100) tick();
      chk_word(grant_cyc, 16'h0);
      chk_bit(dma_busy, 1'b1);
      {dma_enable, card_on} = 2'b11;
      wait_dma();
      chk_bit(done, 1'b1);
      chk_word(rd_falls, 16'h1);
      $display("test dma_off done");
   endtask : t_dma_off
   initial begin
      repeat (4) @(posedge clk);
      #1;
      reset = 0;
      tick();
      chk_bit(disk_n, 1'b1);
      chk_bit(grant_n, 1'b1);
      t_io_mode();
      t_mem_mode();
      t_ide_dma();
      t_dma_off();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule : cfh_host_tb
